// file: rtl/slc_lamp_ctrl.v
// status lamp controller: green run lamp and yellow calibration lamp
// assumes status inputs come from other logic, possibly another clock, so all are synchronised
// assumes nrst is asynchronous and active low
`timescale 1ns/1ps
`include "slc_defs.vh"

// Summary of operation
// - the green lamp is steady on while the link is up and there is no fault.
// - after power-on, while waiting for init data, the green lamp flashes 4 times per second.
// - erroneous init data keeps the link down and the green lamp flashing.
// - a lost link makes the green lamp flash, and a restored link makes it steady again.
// - the green lamp is off on a module fault and when unpowered (in reset).
// - the yellow lamp meaning follows the selected mode, running or calibration; the green lamp ignores the mode.
// - in running mode the yellow lamp is always off.
// - in calibration mode with link up, no fault and no run active, the yellow lamp flashes 4 times per second.
// - while a calibration and detection run is active in calibration mode with link up and no fault, the yellow lamp is steady on.
// - when a run finishes, the yellow lamp returns to flashing.
// - in calibration mode without a link, the yellow lamp is off whatever the run state.
// - the link status shown is that of the fieldbus used to upload measurements.
module slc_lamp_ctrl #(
  parameter [`SLC_CNT_W-1:0] HALF_PERIOD = `SLC_HALF_PERIOD_CYC
) (
  clk,
  nrst,
  link_up,
  init_err,
  module_fault,
  cal_mode,
  cal_active,
  run_lamp,
  cal_lamp
);
  input wire clk;
  input wire nrst;
  input wire link_up;
  input wire init_err;
  input wire module_fault;
  input wire cal_mode;
  input wire cal_active;
  output wire run_lamp;
  output wire cal_lamp;

  // ****************************************
  // input synchronisers
  // ****************************************
  wire link_s;
  wire err_s;
  wire fault_s;
  wire mode_s;
  wire act_s;

  slc_sync2 u_sync_link (
    .clk(clk),
    .nrst(nrst),
    .d(link_up),
    .q(link_s)
  );
  slc_sync2 u_sync_err (
    .clk(clk),
    .nrst(nrst),
    .d(init_err),
    .q(err_s)
  );
  slc_sync2 u_sync_fault (
    .clk(clk),
    .nrst(nrst),
    .d(module_fault),
    .q(fault_s)
  );
  slc_sync2 u_sync_mode (
    .clk(clk),
    .nrst(nrst),
    .d(cal_mode),
    .q(mode_s)
  );
  slc_sync2 u_sync_act (
    .clk(clk),
    .nrst(nrst),
    .d(cal_active),
    .q(act_s)
  );

  // ****************************************
  // shared flash timebase
  // ****************************************
  localparam [`SLC_CNT_W-1:0] CNT_ONE = {{(`SLC_CNT_W-1){1'b0}}, 1'b1};
  localparam [`SLC_CNT_W-1:0] CNT_ZERO = {`SLC_CNT_W{1'b0}};
  localparam [`SLC_CNT_W-1:0] CNT_LAST = HALF_PERIOD - CNT_ONE;

  reg [`SLC_CNT_W-1:0] cnt_reg;
  reg [`SLC_CNT_W-1:0] cnt_next;
  reg phase_reg;
  reg phase_next;
  wire flash_tc;
  wire flash_lvl;

  assign flash_tc = (cnt_reg >= CNT_LAST);
  assign flash_lvl = phase_reg;

  always @* begin
    if (flash_tc)
      cnt_next = CNT_ZERO;
    else
      cnt_next = cnt_reg + CNT_ONE;
  end

  always @* begin
    if (flash_tc)
      phase_next = ~phase_reg;
    else
      phase_next = phase_reg;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= `SLC_PHASE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ****************************************
  // status decode
  // ****************************************
  wire link_ok;
  wire run_mode;
  wire green_dark;
  wire green_steady;
  wire yellow_dark;
  wire yellow_steady;

  assign link_ok = link_s & ~err_s;
  assign run_mode = ~mode_s;
  assign green_dark = fault_s;
  assign green_steady = ~fault_s & link_ok;
  assign yellow_dark = run_mode | fault_s | ~link_ok;
  assign yellow_steady = act_s;

  // ****************************************
  // lamp state machines
  // ****************************************
  localparam [2:0] G_OFF = 3'h1;
  localparam [2:0] G_FLASH = 3'h2;
  localparam [2:0] G_ON = 3'h4;
  localparam [2:0] Y_OFF = 3'h1;
  localparam [2:0] Y_FLASH = 3'h2;
  localparam [2:0] Y_ON = 3'h4;

  reg [2:0] g_reg;
  reg [2:0] g_next;
  reg [2:0] y_reg;
  reg [2:0] y_next;

  always @* begin
    case (g_reg)
      G_OFF: begin
        if (green_dark)
          g_next = G_OFF;
        else if (green_steady)
          g_next = G_ON;
        else
          g_next = G_FLASH;
      end

      G_FLASH: begin
        if (green_dark)
          g_next = G_OFF;
        else if (green_steady)
          g_next = G_ON;
        else
          g_next = G_FLASH;
      end

      G_ON: begin
        if (green_dark)
          g_next = G_OFF;
        else if (green_steady)
          g_next = G_ON;
        else
          g_next = G_FLASH;
      end

      default: begin
        g_next = G_OFF;
      end
    endcase
  end

  always @* begin
    case (y_reg)
      Y_OFF: begin
        if (yellow_dark)
          y_next = Y_OFF;
        else if (yellow_steady)
          y_next = Y_ON;
        else
          y_next = Y_FLASH;
      end

      Y_FLASH: begin
        if (yellow_dark)
          y_next = Y_OFF;
        else if (yellow_steady)
          y_next = Y_ON;
        else
          y_next = Y_FLASH;
      end

      Y_ON: begin
        if (yellow_dark)
          y_next = Y_OFF;
        else if (yellow_steady)
          y_next = Y_ON;
        else
          y_next = Y_FLASH;
      end

      default: begin
        y_next = Y_OFF;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      g_reg <= G_OFF;
    end else begin
      g_reg <= g_next;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      y_reg <= Y_OFF;
    end else begin
      y_reg <= y_next;
    end
  end

  // ****************************************
  // lamp drives
  // ****************************************
  reg run_lamp_reg;
  reg run_lamp_next;
  reg cal_lamp_reg;
  reg cal_lamp_next;

  always @* begin
    case (g_reg)
      G_ON: begin
        run_lamp_next = `SLC_LAMP_ON;
      end

      G_FLASH: begin
        run_lamp_next = flash_lvl;
      end

      G_OFF: begin
        run_lamp_next = `SLC_LAMP_OFF;
      end

      default: begin
        run_lamp_next = `SLC_LAMP_OFF;
      end
    endcase
  end

  always @* begin
    case (y_reg)
      Y_ON: begin
        cal_lamp_next = `SLC_LAMP_ON;
      end

      Y_FLASH: begin
        cal_lamp_next = flash_lvl;
      end

      Y_OFF: begin
        cal_lamp_next = `SLC_LAMP_OFF;
      end

      default: begin
        cal_lamp_next = `SLC_LAMP_OFF;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_lamp_reg <= `SLC_LAMP_OFF;
    end else begin
      run_lamp_reg <= run_lamp_next;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_lamp_reg <= `SLC_LAMP_OFF;
    end else begin
      cal_lamp_reg <= cal_lamp_next;
    end
  end

  assign run_lamp = run_lamp_reg;
  assign cal_lamp = cal_lamp_reg;
endmodule

// file: rtl/slc_sync2.v
// two flip-flop synchroniser for one level input
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module slc_sync2 (
  clk,
  nrst,
  d,
  q
);
  input wire clk;
  input wire nrst;
  input wire d;
  output wire q;
  reg meta_reg;
  reg q_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// file: shared/slc_defs.vh
// constants for the status lamp controller
// assumes a 40 mhz module clock
`ifndef SLC_DEFS_VH
`define SLC_DEFS_VH
`define SLC_CLK_HZ 40000000
`define SLC_FLASH_PER_SEC 4
`define SLC_HALF_PERIOD_CYC 23'h4c4b40
`define SLC_PHASE_RST 1'b1
`define SLC_CNT_W 23
`define SLC_LAMP_OFF 1'b0
`define SLC_LAMP_ON 1'b1
`endif

// file: verif/slc_lamp_ctrl_properties.sv
// lamp controller assertions
// assumes a half period of 8 cycles
`timescale 1ns/1ps
module slc_chk #(parameter HALF_PERIOD = 8) (
  input wire clk,
  input wire nrst,
  input wire link_up,
  input wire init_err,
  input wire module_fault,
  input wire cal_mode,
  input wire cal_active,
  input wire run_lamp,
  input wire cal_lamp
);
  localparam H = HALF_PERIOD;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire ok = link_up & ~init_err & ~module_fault;
  sequence held(c);
    c[*7] ##1 c[*7];
  endsequence
  AST_RUN_ON: assert property (ok[*6] |-> run_lamp)
    else $error("run lamp off");
  AST_RUN_FL: assert property (held(~link_up & ~module_fault) |-> run_lamp != $past(run_lamp, H))
    else $error("run lamp steady");
  AST_ERR_FL: assert property (held(init_err & ~module_fault) |-> run_lamp != $past(run_lamp, H))
    else $error("run lamp steady");
  AST_FAULT: assert property (module_fault[*6] |-> !run_lamp && !cal_lamp)
    else $error("lamp lit");
  AST_RUN_MODE: assert property ((!cal_mode)[*6] |-> !cal_lamp)
    else $error("cal lamp lit");
  AST_CAL_FL: assert property (held(cal_mode & ~cal_active & ok) |-> cal_lamp != $past(cal_lamp, H))
    else $error("cal lamp steady");
  AST_CAL_ON: assert property ((cal_mode & cal_active & ok)[*6] |-> cal_lamp)
    else $error("cal lamp off");
  AST_CAL_DN: assert property ((cal_mode & ~ok)[*6] |-> !cal_lamp)
    else $error("cal lamp lit");
  AST_DUTY: assert property (held(~ok) ##0 $rose(run_lamp) |-> !$past(run_lamp, H) && $past(run_lamp, H + 1))
    else $error("flash duty");
endmodule
bind slc_lamp_ctrl slc_chk #(.HALF_PERIOD(HALF_PERIOD)) u_chk (.clk(clk), .nrst(nrst),
  .link_up(link_up), .init_err(init_err), .module_fault(module_fault), .cal_mode(cal_mode),
  .cal_active(cal_active), .run_lamp(run_lamp), .cal_lamp(cal_lamp));

// file: verif/slc_lamp_ctrl_tb.sv
// bench for the lamp controller
// assumes the link model plays the bus controller
`timescale 1ns/1ps
module slc_lamp_ctrl_tb;
  reg clk = 0, nrst = 0, fault = 0, cmode = 0, cact = 0, up = 0, bad = 0, r0, c0;
  wire link_up, init_err, run_lamp, cal_lamp;
  reg [8:0] rows [0:9];
  integer fail_count = 0, n_compared = 0, i;
  always #12.5 clk = ~clk;
  slc_link_model ctl (.clk(clk), .up(up), .bad(bad), .link_up(link_up), .init_err(init_err));
  slc_lamp_ctrl #(.HALF_PERIOD(8)) uut (.clk(clk), .nrst(nrst), .link_up(link_up),
    .init_err(init_err), .module_fault(fault), .cal_mode(cmode), .cal_active(cact),
    .run_lamp(run_lamp), .cal_lamp(cal_lamp));
  task check(input seen, input exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t lamp mismatch", $time);
      end
    end
  endtask
  // code 2 means flashing
  task look(input [1:0] code, input a, input b);
    begin
      if (code[1]) begin
        check(a ^ b, 1'b1);
      end else begin
        check(a, code[0]);
        check(b, code[0]);
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #20000;
    fail_count = fail_count + 1;
    test_done;
  end
  // fault, mode, active, up, bad, run, cal
  initial begin
    rows[0] = 9'h024; rows[1] = 9'h008; rows[2] = 9'h038; rows[3] = 9'h120;
    rows[4] = 9'h0a6; rows[5] = 9'h0e5; rows[6] = 9'h0a6; rows[7] = 9'h0c8;
    rows[8] = 9'h1e0; rows[9] = 9'h024;
    repeat (10) @(posedge clk);
    nrst <= 1;
    for (i = 0; i < 10; i = i + 1) begin
      {fault, cmode, cact, up, bad} <= rows[i][8:4];
      repeat (16) @(negedge clk);
      r0 = run_lamp;
      c0 = cal_lamp;
      repeat (8) @(negedge clk);
      look(rows[i][3:2], r0, run_lamp);
      look(rows[i][1:0], c0, cal_lamp);
      $display("row %0d done", i);
      @(posedge clk);
    end
    nrst <= 0;
    up <= 0;
    @(negedge clk);
    check(run_lamp | cal_lamp, 1'b0);
    @(posedge clk);
    nrst <= 1;
    repeat (16) @(negedge clk);
    r0 = run_lamp;
    repeat (8) @(negedge clk);
    look(2'h2, r0, run_lamp);
    $display("reset test done");
    test_done;
  end
endmodule

// file: verif/slc_link_model.sv
// bus controller stand-in
// assumes the bench requests link and bad init data
`timescale 1ns/1ps
module slc_link_model (
  input wire clk,
  input wire up,
  input wire bad,
  output reg link_up,
  output reg init_err
);
  always @(posedge clk) begin
    link_up <= up;
    init_err <= bad;
  end
endmodule
